//--- pst_pkg.sv
/*
 * Package of the phase selective trip block: mode encoding, register map,
 * timing constants and field positions.
 * Assumes a 10 MHz system clock and a 32-bit plain register port.
 */
package pst_pkg;

	// ------------------------------------------------------------------
	// Operating mode
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PST_MODE_OFF    = 2'h0,
		PST_MODE_THREE  = 2'h1,
		PST_MODE_SINGLE = 2'h2
	} pst_mode_type;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLOCK_HZ        = 10000000;
	localparam int TICK_TIME_US    = 1000;
	localparam int TICK_CYCLES     = CLOCK_HZ / 1000000 * TICK_TIME_US;
	localparam int MS_W            = 16;
	localparam logic [15:0] PULSE_MIN_MS   = 16'h0032;
	localparam logic [15:0] PULSE_MAX_MS   = 16'hea60;
	localparam logic [15:0] PULSE_DEF_MS   = 16'h0096;
	localparam logic [15:0] EVOLVE_DEF_MS  = 16'h03e8;

	// ------------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_MODE    = 8'h00;
	localparam logic [7:0] REG_PULSE   = 8'h04;
	localparam logic [7:0] REG_EVOLVE  = 8'h08;
	localparam logic [7:0] REG_STATE   = 8'h0c;
	localparam logic [7:0] REG_EVENT   = 8'h10;
	localparam logic [7:0] REG_MASK    = 8'h14;
	localparam logic [7:0] REG_CONTACT = 8'h18;

	// Event bits: on events in 0..3, off events in 4..7
	localparam int EV_W       = 8;
	localparam int EV_OFF_POS = 4;
	localparam int MODE_W     = 2;

	// Trip status bit order: a, b, c, any, all
	localparam int ST_ANY = 3;
	localparam int ST_ALL = 4;
	localparam int ST_W   = 5;

	// Contact routing: two bits per contact, 3 means unassigned
	localparam int CONTACT_N      = 6;
	localparam int CONTACT_SEL_W  = 2;
	localparam logic [11:0] CONTACT_DEF = 12'hfe4;

endpackage

//--- pst_timer.sv
/*
 * Millisecond down counter used for the pulse stretch and evolving-fault
 * windows. Assumes a one-cycle tick input and synchronous reset domain copy.
 */
`timescale 1ns/1ps
module pst_timer #(
	parameter int W = 16
) (
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic         tick_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] value_i,
	output logic              busy_o
);
	logic [W-1:0] count_q;
	logic [W-1:0] count_d;

	assign count_d = load_i ? value_i :
	                 (tick_i && count_q != '0) ? count_q - W'(1) : count_q;
	assign busy_o  = (count_q != '0);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end
endmodule

//--- pst_trip.sv
/*
 * Phase selective trip decision block: widens requests, stretches trips
 * to a minimum pulse, holds three-phase tripping during the evolving-fault
 * window, reports phase and any-trip output changes as events and routes contacts.
 * Assumes request inputs arrive asynchronously and a plain register port.
 */
// The plain strobed port and the register offsets were chosen for this implementation.
// Behaviour
// RULE_01: Mode setting has off, three-phase only, single/three; resets to off.
// RULE_02: Mode off drives no trip output whatever the requests.
// RULE_03: Each trip lasts at least the settable minimum pulse, default 150 ms; the code can end a trip up to one 1 ms tick short.
// RULE_04: A two-phase request trips all three phases.
// RULE_05: Force input turns any single-phase trip into three-phase trip.
// RULE_06: After a trip, evolving-fault window makes every trip three-phase.
// RULE_07: Three-phase request drives all phase outputs and all-phase output.
// RULE_08: Single-phase request with phase requests trips only faulted phase.
// RULE_09: Phase request a, b, c maps to phase trip a, b, c.
// RULE_10: Block input suppresses every output; the code leaves irq_o and rdata_o unblocked.
// RULE_11: Any-trip output is high whenever any trip is commanded.
// RULE_12: All-phase output is high whenever all three phases trip.
// RULE_13: Each change of phase and any-trip outputs logs an on or off event.
// RULE_14: First three contacts default to phase a, b, c; contacts may share.
// RULE_15: Three-phase only mode widens any request to all three phases.
// RULE_16: Timers count a 1 ms tick; reset clears timers and outputs.
`timescale 1ns/1ps
module pst_trip #(
	parameter int TICK_CYCLES = pst_pkg::TICK_CYCLES,
	parameter int CONTACT_N   = pst_pkg::CONTACT_N
) (
	input  wire logic                  clock_i,
	input  wire logic                  arst_n_i,
	input  wire logic                  block_outputs_in_i,
	input  wire logic                  single_phase_request_in_i,
	input  wire logic                  three_phase_request_in_i,
	input  wire logic                  phase_a_request_in_i,
	input  wire logic                  phase_b_request_in_i,
	input  wire logic                  phase_c_request_in_i,
	input  wire logic                  force_all_phases_in_i,
	input  wire logic [7:0]            addr_i,
	input  wire logic [31:0]           wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [31:0]           rdata_o,
	output logic                       phase_a_trip_out_o,
	output logic                       phase_b_trip_out_o,
	output logic                       phase_c_trip_out_o,
	output logic                       any_trip_out_o,
	output logic                       all_phase_trip_out_o,
	output logic      [CONTACT_N-1:0]  contact_o,
	output logic                       irq_o
);
	// ------------------------------------------------------------------
	// Reset release and input synchronisers
	// ------------------------------------------------------------------
	logic       rst_meta_q;
	logic       rst_n_q;
	logic [6:0] in_meta_q;
	logic [6:0] in_sync_q;
	logic [6:0] in_raw;

	assign in_raw = {force_all_phases_in_i, phase_c_request_in_i, phase_b_request_in_i,
	                 phase_a_request_in_i, three_phase_request_in_i,
	                 single_phase_request_in_i, block_outputs_in_i};

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			in_meta_q <= 7'h00;
			in_sync_q <= 7'h00;
		end else begin
			in_meta_q <= in_raw;
			in_sync_q <= in_meta_q;
		end
	end

	wire       blk_s    = in_sync_q[0];
	wire       req1_s   = in_sync_q[1];
	wire       req3_s   = in_sync_q[2];
	wire [2:0] phase_s  = in_sync_q[5:3];
	wire       force_s  = in_sync_q[6];

	// ------------------------------------------------------------------
	// Settings registers
	// ------------------------------------------------------------------
	pst_pkg::pst_mode_type mode_q;
	logic [15:0]           pulse_q;
	logic [15:0]           evolve_q;
	logic [pst_pkg::EV_W-1:0] event_q;
	logic [pst_pkg::EV_W-1:0] event_d;
	logic [pst_pkg::EV_W-1:0] mask_q;
	logic [CONTACT_N*pst_pkg::CONTACT_SEL_W-1:0] route_q;

	// Settings outside the documented range are clamped
	function automatic logic [15:0] clamp_ms(input logic [15:0] v);
		if (v < pst_pkg::PULSE_MIN_MS) begin
			clamp_ms = pst_pkg::PULSE_MIN_MS;
		end else if (v > pst_pkg::PULSE_MAX_MS) begin
			clamp_ms = pst_pkg::PULSE_MAX_MS;
		end else begin
			clamp_ms = v;
		end
	endfunction

	wire wr_mode    = wr_i && addr_i == pst_pkg::REG_MODE;
	wire wr_pulse   = wr_i && addr_i == pst_pkg::REG_PULSE;
	wire wr_evolve  = wr_i && addr_i == pst_pkg::REG_EVOLVE;
	wire wr_event   = wr_i && addr_i == pst_pkg::REG_EVENT;
	wire wr_mask    = wr_i && addr_i == pst_pkg::REG_MASK;
	wire wr_contact = wr_i && addr_i == pst_pkg::REG_CONTACT;

	wire [1:0] mode_wr = wdata_i[pst_pkg::MODE_W-1:0];
	wire       mode_ok = (mode_wr == pst_pkg::PST_MODE_THREE) || (mode_wr == pst_pkg::PST_MODE_SINGLE);

	// RULE_01 mode setting
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q   <= pst_pkg::PST_MODE_OFF;
			pulse_q  <= pst_pkg::PULSE_DEF_MS;
			evolve_q <= pst_pkg::EVOLVE_DEF_MS;
			mask_q   <= '0;
			route_q  <= pst_pkg::CONTACT_DEF;
		end else begin
			if (wr_mode) begin
				mode_q <= mode_ok ? pst_pkg::pst_mode_type'(mode_wr) : pst_pkg::PST_MODE_OFF;
			end
			if (wr_pulse) begin
				pulse_q <= clamp_ms(wdata_i[15:0]);
			end
			if (wr_evolve) begin
				evolve_q <= clamp_ms(wdata_i[15:0]);
			end
			if (wr_mask) begin
				mask_q <= wdata_i[pst_pkg::EV_W-1:0];
			end
			if (wr_contact) begin
				route_q <= wdata_i[CONTACT_N*pst_pkg::CONTACT_SEL_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Millisecond tick
	// ------------------------------------------------------------------
	localparam int TW = $clog2(TICK_CYCLES + 1);
	logic [TW-1:0] tick_cnt_q;
	logic          tick_q;
	wire           tick_wrap = (tick_cnt_q == TW'(TICK_CYCLES - 1));

	// RULE_16 ms tick
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else begin
			tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + TW'(1);
			tick_q     <= tick_wrap;
		end
	end

	// ------------------------------------------------------------------
	// Decision logic
	// ------------------------------------------------------------------
	logic [2:0] held_q;
	logic       pulse_busy;
	logic       evolve_busy;
	wire        enabled = (mode_q != pst_pkg::PST_MODE_OFF) && !blk_s;
	wire [1:0]  phase_cnt = 2'(phase_s[0]) + 2'(phase_s[1]) + 2'(phase_s[2]);
	wire        any_req = req1_s || req3_s || (phase_s != 3'h0);

	// RULE_08 single-phase only with request and one phase in single mode
	wire single_ok = (mode_q == pst_pkg::PST_MODE_SINGLE) && req1_s && (phase_cnt == 2'h1);
	// RULE_04 two phases widen
	wire multi_ph  = (phase_cnt >= 2'h2);
	// RULE_05 force input, RULE_06 evolving window, RULE_07 three-phase request, RULE_15 3ph mode
	wire widen     = req3_s || multi_ph || force_s || evolve_busy || !single_ok;
	// RULE_09 phase mapping
	wire [2:0] req_ph  = !any_req ? 3'h0 : (widen ? 3'h7 : phase_s);
	// RULE_02 off mode, RULE_10 block
	wire [2:0] new_ph  = enabled ? req_ph : 3'h0;
	wire       new_trip = (new_ph != 3'h0);

	// RULE_03 pulse stretch; a fresh request restarts the minimum pulse
	wire [2:0] comb_ph   = new_ph | (pulse_busy ? held_q : 3'h0);
	// RULE_04 held plus new phase widens, RULE_05 force widens held pulse
	wire       comb_wide = ((comb_ph & (comb_ph - 3'h1)) != 3'h0) || (force_s && (comb_ph != 3'h0));
	wire [2:0] trip_ph   = !enabled ? 3'h0 : (comb_wide ? 3'h7 : comb_ph);
	wire       trip_on = (trip_ph != 3'h0);

	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			held_q <= 3'h0;
		end else begin
			held_q <= trip_ph;
		end
	end

	pst_timer #(
		.W (pst_pkg::MS_W)
	) u_pulse (
		.clock_i (clock_i),
		.rst_n_i (rst_n_q),
		.tick_i  (tick_q),
		.load_i  (new_trip),
		.value_i (pulse_q),
		.busy_o  (pulse_busy)
	);

	// RULE_06 window armed on each trip end
	wire trip_fall = (held_q != 3'h0) && !trip_on;

	pst_timer #(
		.W (pst_pkg::MS_W)
	) u_evolve (
		.clock_i (clock_i),
		.rst_n_i (rst_n_q),
		.tick_i  (tick_q),
		.load_i  (trip_fall),
		.value_i (evolve_q),
		.busy_o  (evolve_busy)
	);

	// ------------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------------
	logic [pst_pkg::ST_W-1:0] stat_q;
	wire  [pst_pkg::ST_W-1:0] stat_d;

	// RULE_11 any trip, RULE_12 all phases
	assign stat_d = {(trip_ph == 3'h7), trip_on, trip_ph};

	// RULE_16 reset clears outputs
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			stat_q <= '0;
		end else begin
			stat_q <= stat_d;
		end
	end

	// RULE_13 on and off events
	wire [3:0] rise = stat_d[3:0] & ~stat_q[3:0];
	wire [3:0] fall = ~stat_d[3:0] & stat_q[3:0];
	wire [pst_pkg::EV_W-1:0] ev_set = {fall, rise};

	// Set wins over write-one-to-clear
	assign event_d = (event_q & ~(wr_event ? wdata_i[pst_pkg::EV_W-1:0] : '0)) | ev_set;

	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			event_q <= '0;
			irq_o   <= 1'b0;
		end else begin
			event_q <= event_d;
			irq_o   <= |(event_d & mask_q);
		end
	end

	// RULE_14 contact routing
	logic [CONTACT_N-1:0] contact_d;
	genvar gi;
	generate
		for (gi = 0; gi < CONTACT_N; gi++) begin : g_contact
			wire [1:0] sel = route_q[gi*pst_pkg::CONTACT_SEL_W +: pst_pkg::CONTACT_SEL_W];
			assign contact_d[gi] = (sel == 2'h3) ? 1'b0 : stat_d[sel];
		end
	endgenerate

	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			contact_o <= '0;
		end else begin
			contact_o <= contact_d;
		end
	end

	assign phase_a_trip_out_o   = stat_q[0];
	assign phase_b_trip_out_o   = stat_q[1];
	assign phase_c_trip_out_o   = stat_q[2];
	assign any_trip_out_o       = stat_q[pst_pkg::ST_ANY];
	assign all_phase_trip_out_o = stat_q[pst_pkg::ST_ALL];

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (addr_i)
			pst_pkg::REG_MODE:    rd_mux = {30'h0, mode_q};
			pst_pkg::REG_PULSE:   rd_mux = {16'h0, pulse_q};
			pst_pkg::REG_EVOLVE:  rd_mux = {16'h0, evolve_q};
			pst_pkg::REG_STATE:   rd_mux = {25'h0, pulse_busy, evolve_busy, stat_q};
			pst_pkg::REG_EVENT:   rd_mux = {24'h0, event_q};
			pst_pkg::REG_MASK:    rd_mux = {24'h0, mask_q};
			pst_pkg::REG_CONTACT: rd_mux = {20'h0, route_q};
			default:              rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_o <= 32'h0000_0000;
		end else begin
			rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
		end
	end
endmodule

//--- pst_trip_assertions.sv
/* Port assertions for the phase selective trip block.
   Bound to pst_trip from the bench; TICK_CYCLES matches the instance. */
`timescale 1ns/1ps
module pst_trip_assertions #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic        clock_i,
	input wire logic        arst_n_i,
	input wire logic        block_outputs_in_i,
	input wire logic        three_phase_request_in_i,
	input wire logic        force_all_phases_in_i,
	input wire logic [7:0]  addr_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        phase_a_trip_out_o,
	input wire logic        phase_b_trip_out_o,
	input wire logic        phase_c_trip_out_o,
	input wire logic        any_trip_out_o,
	input wire logic        all_phase_trip_out_o
);
	localparam int MIN_HI = 50 * TICK_CYCLES - TICK_CYCLES;
	logic [15:0] hi_q;
	logic        cut_q;
	wire  [2:0]  ph = {phase_c_trip_out_o, phase_b_trip_out_o, phase_a_trip_out_o};

	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	// Pulse length, unless blocked or mode rewritten
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hi_q  <= 16'h0000;
			cut_q <= 1'b0;
		end else begin
			hi_q  <= any_trip_out_o ? hi_q + 16'h0001 : 16'h0000;
			cut_q <= any_trip_out_o & (cut_q | block_outputs_in_i | (wr_i && addr_i == pst_pkg::REG_MODE));
		end
	end

	property p_min_pulse;
		$fell(any_trip_out_o) && !cut_q |-> int'(hi_q) >= MIN_HI;
	endproperty
	a_min_pulse: assert property (p_min_pulse)
		else $error("trip pulse too short");
	property p_block;
		block_outputs_in_i [*3] |=> ph == 3'h0 && !any_trip_out_o && !all_phase_trip_out_o;
	endproperty
	a_block: assert property (p_block)
		else $error("output while blocked");
	property p_any_or;
		any_trip_out_o == (|ph);
	endproperty
	a_any_or: assert property (p_any_or)
		else $error("general trip not the or of phases");
	property p_all_and;
		all_phase_trip_out_o == (&ph);
	endproperty
	a_all_and: assert property (p_all_and)
		else $error("three phase trip not the and of phases");
	property p_two_widen;
		$countones(ph) >= 2 |-> ph == 3'h7;
	endproperty
	a_two_widen: assert property (p_two_widen)
		else $error("two phase trip not widened");
	property p_req_three;
		three_phase_request_in_i [*3] ##1 any_trip_out_o |-> all_phase_trip_out_o;
	endproperty
	a_req_three: assert property (p_req_three)
		else $error("three phase request tripped fewer phases");
	property p_force;
		force_all_phases_in_i [*3] ##1 any_trip_out_o |-> ph == 3'h7;
	endproperty
	a_force: assert property (p_force)
		else $error("forced trip not three phase");
	property p_rdata_idle;
		!rd_i |=> rdata_o == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside its cycle");
	property p_reset_quiet;
		$rose(arst_n_i) |-> !any_trip_out_o ##1 !any_trip_out_o;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("trip right after reset");
endmodule

//--- pst_req_model.sv
/* Upstream protection function model: raises a request pattern for a
   given number of cycles after a one-cycle go strobe from the bench. */
`timescale 1ns/1ps
module pst_req_model (
	input  wire logic       clock_i,
	input  wire logic       go_i,
	input  wire logic [5:0] pat_i,
	input  wire logic [7:0] len_i,
	output logic      [5:0] req_o
);
	logic [5:0] pat_q = 6'h00;
	logic [7:0] cnt_q = 8'h00;
	always_ff @(posedge clock_i) begin
		if (go_i) begin
			pat_q <= pat_i;
			cnt_q <= len_i;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
	// Released requests fall back to inactive
	assign req_o = (cnt_q != 8'h00) ? pat_q : 6'h00;
endmodule

//--- pst_trip_bench.sv
/* Self-checking bench of pst_trip with a request source model.
   Requests {force,3ph,single,c,b,a}; status reads checked via a queue. */
`timescale 1ns/1ps
module pst_trip_bench;
	logic        clock_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        blk = 1'b0;
	logic        go = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_p = 1'b0;
	logic [5:0]  pat = 6'h00;
	logic [7:0]  len = 8'h03;
	logic [5:0]  req;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ta, tb, tc, tany, tall, irq;
	logic [5:0]  cont;
	logic [63:0] exp_q[$];
	logic [63:0] e_n;
	logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1c};
	logic [31:0] rv[6] = '{32'h0, 32'h96, 32'h3e8, 32'h0, 32'hfe4, 32'h0};
	logic [5:0]  wp[4] = '{6'h0b, 6'h29, 6'h10, 6'h01};
	int          num_errors = 0;
	int          checked = 0;

	always #50 clock_i = ~clock_i;

	pst_req_model u_src (.clock_i(clock_i), .go_i(go), .pat_i(pat), .len_i(len), .req_o(req));
	pst_trip #(.TICK_CYCLES(10), .CONTACT_N(6)) dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.block_outputs_in_i(blk), .single_phase_request_in_i(req[3]), .three_phase_request_in_i(req[4]),
		.phase_a_request_in_i(req[0]), .phase_b_request_in_i(req[1]), .phase_c_request_in_i(req[2]),
		.force_all_phases_in_i(req[5]), .addr_i(addr), .wdata_i(wdat), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdat), .phase_a_trip_out_o(ta), .phase_b_trip_out_o(tb), .phase_c_trip_out_o(tc),
		.any_trip_out_o(tany), .all_phase_trip_out_o(tall), .contact_o(cont), .irq_o(irq));

	task automatic final_report();
		$display("compares %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(logic [31:0] got, logic [31:0] exp, string m);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	// Read result watcher
	always @(posedge clock_i) begin
		if (rd_p) begin
			e_n = exp_q.pop_front();
			cmp(rdat & e_n[63:32], e_n[31:0], "read data");
		end
		rd_p <= rd;
	end
	task automatic wr_reg(logic [7:0] a, logic [31:0] d);
		@(posedge clock_i); wr <= 1'b1; addr <= a; wdat <= d;
		@(posedge clock_i); wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [7:0] a, logic [31:0] m, logic [31:0] e);
		exp_q.push_back({m, e});
		@(posedge clock_i); rd <= 1'b1; addr <= a;
		@(posedge clock_i); rd <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic fire(logic [5:0] p);
		@(posedge clock_i); go <= 1'b1; pat <= p; len <= 8'(3 + $urandom % 16);
		@(posedge clock_i); go <= 1'b0;
	endtask
	task automatic wait_any(logic v);
		int n;
		n = 0;
		while (tany !== v && n < 2000) begin
			@(negedge clock_i);
			n++;
		end
		if (n >= 2000) begin
			num_errors++;
			$display("MISMATCH %0t trip wait timed out", $time);
			final_report();
		end
	endtask
	task automatic trip(logic [5:0] p, logic [31:0] e);
		fire(p); wait_any(1'b1);
		cmp({27'h0, tall, tany, tc, tb, ta}, e, "trip outputs");
		rd_reg(pst_pkg::REG_STATE, 32'h1f, e); wait_any(1'b0);
	endtask
	task automatic idle();
		repeat (700) @(posedge clock_i);
	endtask

	initial begin
		void'($urandom(68303));
		repeat (16) @(posedge clock_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		for (int i = 0; i < 6; i++) rd_reg(ra[i], 32'hffffffff, rv[i]);
		fire(6'h10); repeat (30) @(posedge clock_i);
		rd_reg(pst_pkg::REG_STATE, 32'h1f, 32'h0);
		wr_reg(pst_pkg::REG_PULSE, 32'h0a); rd_reg(pst_pkg::REG_PULSE, 32'hffff, 32'h32);
		wr_reg(pst_pkg::REG_EVOLVE, 32'h32); wr_reg(pst_pkg::REG_MODE, 32'h2);
		$display("end reset and mode off");
		for (int i = 0; i < 3; i++) begin
			trip(6'h08 | 6'(1 << i), 32'h08 | (32'h1 << i));
			idle();
		end
		rd_reg(pst_pkg::REG_EVENT, 32'hff, 32'hff);
		wr_reg(pst_pkg::REG_MASK, 32'h01); repeat (2) @(negedge clock_i);
		cmp({31'h0, irq}, 32'h1, "irq raised");
		wr_reg(pst_pkg::REG_EVENT, 32'hff); rd_reg(pst_pkg::REG_EVENT, 32'hff, 32'h0);
		@(negedge clock_i); cmp({31'h0, irq}, 32'h0, "irq cleared");
		$display("end single phase and events");
		trip(6'h09, 32'h09); trip(6'h0a, 32'h1f); idle();
		for (int i = 0; i < 4; i++) begin
			trip(wp[i], 32'h1f);
			idle();
		end
		fire(6'h09); wait_any(1'b1); fire(6'h0a); repeat (4) @(negedge clock_i);
		cmp({27'h0, tall, tany, tc, tb, ta}, 32'h1f, "second phase in pulse");
		wait_any(1'b0); idle();
		wr_reg(pst_pkg::REG_CONTACT, 32'hf24); fire(6'h09); wait_any(1'b1);
		cmp({26'h0, cont}, 32'h09, "contact routing");
		wait_any(1'b0); idle();
		wr_reg(pst_pkg::REG_MODE, 32'h1); trip(6'h09, 32'h1f); idle();
		$display("end widening");
		fire(6'h10); wait_any(1'b1);
		@(posedge clock_i); blk <= 1'b1;
		repeat (4) @(negedge clock_i);
		cmp({31'h0, tany}, 32'h0, "blocked mid pulse");
		fire(6'h10); repeat (30) @(posedge clock_i);
		rd_reg(pst_pkg::REG_STATE, 32'h1f, 32'h0);
		idle(); blk <= 1'b0; idle();
		fire(6'h10); wait_any(1'b1);
		@(posedge clock_i); arst_n_i <= 1'b0;
		@(negedge clock_i); cmp({31'h0, tany}, 32'h0, "reset clears trip");
		repeat (16) @(posedge clock_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rd_reg(pst_pkg::REG_MODE, 32'h3, 32'h0);
		$display("end block and reset");
		final_report();
	end
endmodule

bind pst_trip pst_trip_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
	.block_outputs_in_i(block_outputs_in_i), .three_phase_request_in_i(three_phase_request_in_i),
	.force_all_phases_in_i(force_all_phases_in_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .phase_a_trip_out_o(phase_a_trip_out_o), .phase_b_trip_out_o(phase_b_trip_out_o),
	.phase_c_trip_out_o(phase_c_trip_out_o), .any_trip_out_o(any_trip_out_o),
	.all_phase_trip_out_o(all_phase_trip_out_o));
